//--- sfc_cal_seq.sv
`timescale 1ns/10ps
// Summary of operation
// - mode code 111 starts system full-scale calibration
// - calibration uses the range bits' gain
// - excitation follows ac select during system cal
// - lasts 22 periods chopped, 24 unchopped
// - mode bits return to idle at end
// - ready_n high at start, low at end
// - only selected gain coefficient updates, no data
// - ready_n may rise up to one modulator cycle
// - reset loads defaults and nominal coefficients
// - chop enable chops the whole chain
// - mode code 110 runs system zero-scale cal
// - mode code 101 runs internal full-scale cal
module sfc_cal_seq
	import sfc_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic [23:0] cal_meas_word,
	input  wire logic        conv_strobe,
	input  wire logic [23:0] conv_word,
	output logic             ready_n,
	output logic             cal_busy,
	output logic      [1:0]  pga_range,
	output logic             chan_sel,
	output logic             exc_ac,
	output logic             chop_active,
	output logic             fs_internal,
	output logic             zero_scale_cal
);
	import sfc_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// state and storage
	typedef enum logic [1:0] {
		SFC_ST_IDLE = 2'b00,
		SFC_ST_ARM  = 2'b01,
		SFC_ST_RUN  = 2'b10
	} sfc_state_t;

	sfc_state_t  st_reg;         // sequencer state
	sfc_mode_t   mode_sel_reg;   // mode-select field
	logic [1:0]  range_reg;      // input range field
	logic        ac_reg;         // ac excitation select
	logic        chan_reg;       // channel select
	logic        chop_reg;       // chop enable
	logic [11:0] rdiv_reg;       // modulator cycles per period
	logic        rdy_n_reg;      // ready, active low
	logic [23:0] data_reg;       // conversion result
	logic [23:0] offs_reg [2];   // offset coefficients
	logic [23:0] gain_reg [2];   // gain coefficients
	sfc_mode_t   kind_reg;       // calibration being run
	logic [1:0]  range_lat_reg;  // frozen range
	logic        chan_lat_reg;   // frozen channel
	logic        ac_lat_reg;     // frozen ac select
	logic        chop_lat_reg;   // frozen chop setting
	logic [31:0] prdata_reg;     // read data

	sfc_tim_if tim ();

	////////////////////////////////////////////////////////////////////////
	// bus decode
	wire wr_acc   = psel && penable && pwrite;
	wire rd_setup = psel && !penable && !pwrite;
	wire a_mode   = paddr == SFC_MODE_OFS;
	wire a_filt   = paddr == SFC_FILT_OFS;
	wire a_stat   = paddr == SFC_STAT_OFS;
	wire a_data   = paddr == SFC_DATA_OFS;
	wire a_offs0  = paddr == SFC_OFFS0_OFS;
	wire a_offs1  = paddr == SFC_OFFS1_OFS;
	wire a_gain0  = paddr == SFC_GAIN0_OFS;
	wire a_gain1  = paddr == SFC_GAIN1_OFS;
	wire mapped   = a_mode || a_filt || a_stat || a_data ||
		a_offs0 || a_offs1 || a_gain0 || a_gain1;
	wire idle     = st_reg == SFC_ST_IDLE;
	wire busy     = !idle;
	wire [2:0] wr_md = pwdata[SFC_MD_LSB +: 3];

	// zero-wait slave, error on unmapped access
	assign pready  = 1'b1;
	assign pslverr = psel && penable && !mapped;
	assign prdata  = prdata_reg;

	// calibration command: any code with the top bit set
	wire mode_wr  = wr_acc && a_mode;
	wire cal_take = mode_wr && idle && wr_md[2];
	wire arm_go   = (st_reg == SFC_ST_ARM) && tim.mod_tick;
	wire cal_done = (st_reg == SFC_ST_RUN) && tim.done;
	wire conv_ok  = idle && conv_strobe &&
		(mode_sel_reg == SFC_MD_CONT || mode_sel_reg == SFC_MD_SINGLE);

	////////////////////////////////////////////////////////////////////////
	// read mux
	wire [31:0] rd_mode = {25'h0, chan_reg, ac_reg, range_reg, mode_sel_reg};
	wire [31:0] rd_filt = {16'h0, rdiv_reg, 3'h0, chop_reg};
	wire [31:0] rd_stat = {27'h0, kind_reg, busy, rdy_n_reg};
	wire [31:0] rd_word =
		a_mode  ? rd_mode :
		a_filt  ? rd_filt :
		a_stat  ? rd_stat :
		a_data  ? {8'h0, data_reg} :
		a_offs0 ? {8'h0, offs_reg[0]} :
		a_offs1 ? {8'h0, offs_reg[1]} :
		a_gain0 ? {8'h0, gain_reg[0]} :
		a_gain1 ? {8'h0, gain_reg[1]} : 32'h0;

	// capture read data in the setup cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			prdata_reg <= 32'h0;
		else if (rd_setup)
			prdata_reg <= rd_word;
	end

	////////////////////////////////////////////////////////////////////////
	// timing sub-blocks
	wire [5:0] per_sys = chop_lat_reg ? SFC_SYS_CHOP : SFC_SYS_NOCH;
	wire [5:0] per_int = chop_lat_reg ? SFC_INT_CHOP : SFC_INT_NOCH;
	assign tim.target   = (kind_reg == SFC_MD_IFS) ? per_int : per_sys;
	assign tim.restart  = arm_go;
	assign tim.run      = st_reg == SFC_ST_RUN;
	assign tim.rate_div = rdiv_reg;

	sfc_tick_gen u_tick (
		.pclk    (pclk),
		.presetn (presetn),
		.tim     (tim.gen)
	);

	sfc_period_cnt u_per (
		.pclk    (pclk),
		.presetn (presetn),
		.tim     (tim.cnt)
	);

	////////////////////////////////////////////////////////////////////////
	// sequencer: idle, wait for modulator edge, run
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			st_reg <= SFC_ST_IDLE;
		else
			case (st_reg)
				SFC_ST_IDLE: if (cal_take) st_reg <= SFC_ST_ARM;
				SFC_ST_ARM:  if (arm_go) st_reg <= SFC_ST_RUN;
				SFC_ST_RUN:  if (cal_done) st_reg <= SFC_ST_IDLE;
				default:     st_reg <= SFC_ST_IDLE;
			endcase
	end

	// settings frozen at command acceptance
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			kind_reg      <= SFC_MD_IDLE;
			range_lat_reg <= 2'h0;
			chan_lat_reg  <= 1'b0;
			ac_lat_reg    <= 1'b0;
			chop_lat_reg  <= SFC_CHOP_RST;
		end else if (cal_take) begin
			kind_reg      <= sfc_mode_t'(wr_md);
			range_lat_reg <= pwdata[SFC_RANGE_LSB +: 2];
			chan_lat_reg  <= pwdata[SFC_CHAN_BIT];
			ac_lat_reg    <= pwdata[SFC_AC_BIT];
			chop_lat_reg  <= chop_reg;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// mode and filter registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_sel_reg <= SFC_MD_IDLE;
			range_reg    <= 2'h0;
			ac_reg       <= 1'b0;
			chan_reg     <= 1'b0;
		end else begin
			if (cal_done || (conv_ok && mode_sel_reg == SFC_MD_SINGLE))
				mode_sel_reg <= SFC_MD_IDLE;
			else if (mode_wr && idle)
				mode_sel_reg <= sfc_mode_t'(wr_md);
			if (mode_wr) begin
				range_reg <= pwdata[SFC_RANGE_LSB +: 2];
				ac_reg    <= pwdata[SFC_AC_BIT];
				chan_reg  <= pwdata[SFC_CHAN_BIT];
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			chop_reg <= SFC_CHOP_RST;
			rdiv_reg <= SFC_RDIV_RST;
		end else if (wr_acc && a_filt) begin
			chop_reg <= pwdata[SFC_CHOP_BIT];
			rdiv_reg <= pwdata[SFC_RDIV_LSB +: 12];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// ready line: high once running, low at completion
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			rdy_n_reg <= SFC_RDYN_RST;
		else if (arm_go)
			rdy_n_reg <= 1'b1;
		else if (cal_done || conv_ok)
			rdy_n_reg <= 1'b0;
		else if (mode_wr && idle && wr_md == SFC_MD_STBY)
			rdy_n_reg <= 1'b1;
	end

	// data register: conversions only, never a calibration
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			data_reg <= SFC_DATA_RST;
		else if (conv_ok)
			data_reg <= conv_word;
	end

	////////////////////////////////////////////////////////////////////////
	// coefficients: nominal at reset, result of calibration on completion
	wire upd_gain = cal_done &&
		(kind_reg == SFC_MD_SFS || kind_reg == SFC_MD_IFS);
	wire upd_offs = cal_done && kind_reg != SFC_MD_SFS;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < 2; i++) begin
				offs_reg[i] <= SFC_OFFS_RST;
				gain_reg[i] <= SFC_GAIN_RST;
			end
		end else begin
			if (upd_gain)
				gain_reg[chan_lat_reg] <= cal_meas_word;
			else if (wr_acc && (a_gain0 || a_gain1) && idle)
				gain_reg[a_gain1] <= pwdata[23:0];
			if (upd_offs)
				offs_reg[chan_lat_reg] <= cal_meas_word;
			else if (wr_acc && (a_offs0 || a_offs1) && idle)
				offs_reg[a_offs1] <= pwdata[23:0];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// front-end controls
	wire cal_sys = kind_reg == SFC_MD_SFS || kind_reg == SFC_MD_SZS;
	assign ready_n        = rdy_n_reg;
	assign cal_busy       = busy;
	assign pga_range      = busy ? range_lat_reg : range_reg;
	assign chan_sel       = busy ? chan_lat_reg : chan_reg;
	assign exc_ac         = busy ? (cal_sys && ac_lat_reg) : ac_reg;
	assign chop_active    = busy ? chop_lat_reg : chop_reg;
	assign fs_internal    = busy && kind_reg == SFC_MD_IFS;
	assign zero_scale_cal = busy &&
		(kind_reg == SFC_MD_SZS || kind_reg == SFC_MD_IZS);

	////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	logic [5:0] h_per_reg; // periods seen in run
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			h_per_reg <= 6'h00;
		else if (st_reg != SFC_ST_RUN)
			h_per_reg <= 6'h00;
		else if (tim.rate_tick)
			h_per_reg <= h_per_reg + 6'h01;
	end

	chk_cmd_arms: assert property (cal_take |=> st_reg == SFC_ST_ARM)
		else $error("calibration command not accepted");
	chk_range_latch: assert property (cal_take |=>
		pga_range == $past(pwdata[4:3]))
		else $error("range not taken from command");
	chk_ac_follow: assert property (busy && kind_reg == SFC_MD_SFS
		|-> exc_ac == ac_lat_reg)
		else $error("excitation not per ac select");
	chk_period_count: assert property (cal_done && kind_reg == SFC_MD_SFS
		|-> h_per_reg + 6'h01 == (chop_lat_reg ? 6'd22 : 6'd24))
		else $error("wrong calibration length");
	chk_mode_idle: assert property (cal_done |=>
		mode_sel_reg == SFC_MD_IDLE)
		else $error("mode not cleared after calibration");
	chk_ready_edges: assert property (st_reg == SFC_ST_RUN
		|-> ready_n)
		else $error("ready fell during calibration");
	chk_ready_low: assert property (cal_done |=> !ready_n)
		else $error("ready not low at completion");
	chk_arm_bound: assert property (cal_take |-> ##[2:33]
		st_reg == SFC_ST_RUN)
		else $error("ready rise later than a modulator cycle");
	chk_data_still: assert property (busy |=> $stable(data_reg))
		else $error("data register changed by calibration");
	chk_offs_kept: assert property (cal_done && kind_reg == SFC_MD_SFS
		|=> $stable(offs_reg[0]) && $stable(offs_reg[1]))
		else $error("offset changed by full-scale calibration");
	chk_freeze: assert property (st_reg == SFC_ST_RUN && !cal_done
		|=> $stable(pga_range) && $stable(chan_sel))
		else $error("settings moved during calibration");
	chk_chop_hold: assert property (busy && !cal_done |=>
		$stable(chop_active))
		else $error("chop changed during calibration");
	chk_reset_vals: assert property ($rose(presetn) |->
		gain_reg[0] == SFC_GAIN_RST && offs_reg[1] == SFC_OFFS_RST)
		else $error("coefficients not nominal after reset");

	cov_sfs: cover property (cal_done && kind_reg == SFC_MD_SFS);
	cov_szs: cover property (cal_done && kind_reg == SFC_MD_SZS);
	cov_ifs: cover property (cal_done && kind_reg == SFC_MD_IFS);
	cov_conv: cover property (conv_ok ##1 !ready_n);
endmodule

//--- sfc_cal_seq_tb.sv
`timescale 1ns/10ps
module sfc_cal_seq_tb;
	import sfc_pkg::*;
	logic        pclk;            // 25 MHz bus clock
	logic        presetn;         // async reset, low active
	logic        psel;            // apb select
	logic        penable;         // apb access phase
	logic        pwrite;          // apb direction
	logic [7:0]  paddr;           // apb byte address
	logic [31:0] pwdata;          // apb write data
	logic [31:0] prdata;          // apb read data
	logic        pready;          // apb ready
	logic        pslverr;         // apb error
	logic [23:0] cal_meas_word;   // front-end measurement
	logic        conv_strobe;     // conversion result pulse
	logic [23:0] conv_word;       // conversion result
	logic        ready_n;         // ready, low active
	logic        cal_busy;        // calibration running
	logic [1:0]  pga_range;       // gain range in use
	logic        chan_sel;        // channel in use
	logic        exc_ac;          // ac excitation in use
	logic        chop_active;     // chopping in use
	logic        fs_internal;     // internal full-scale running
	logic        zero_scale_cal;  // zero-scale running
	logic [23:0] fs_lvl;          // level offered to the model
	logic        conv_req;        // ask model for a result
	logic [23:0] conv_val;        // result value offered
	int          fails;           // mismatches seen
	int          samples_checked; // comparisons made

	////////////////////////////////////////////////////////////////////////////
	// design and front-end model
	sfc_cal_seq DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.cal_meas_word(cal_meas_word), .conv_strobe(conv_strobe),
		.conv_word(conv_word), .ready_n(ready_n), .cal_busy(cal_busy),
		.pga_range(pga_range), .chan_sel(chan_sel), .exc_ac(exc_ac),
		.chop_active(chop_active), .fs_internal(fs_internal),
		.zero_scale_cal(zero_scale_cal));
	sfc_front_model FRONT (.pclk(pclk), .presetn(presetn),
		.cal_busy(cal_busy), .fs_level(fs_lvl), .conv_req(conv_req),
		.conv_value(conv_val), .cal_meas_word(cal_meas_word),
		.conv_strobe(conv_strobe), .conv_word(conv_word));

	////////////////////////////////////////////////////////////////////////////
	// clock
	initial begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end

	////////////////////////////////////////////////////////////////////////////
	// compare, verdict
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fails++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic results;
		if (fails == 0 && samples_checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////
	// apb transfer: setup, then access until pready seen at an edge
	task automatic apb_xfer(input logic wr, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q, output logic e);
		int n;
		n = 0;
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1 && n < 50) begin
			@(posedge pclk);
			n++;
		end
		// a slave that never answers counts as a mismatch
		if (n == 50)
			fails++;
		q = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic apb_wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic        e;
		apb_xfer(1'b1, a, d, q, e);
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] q;
		logic        e;
		apb_xfer(1'b0, a, 32'h0, q, e);
		chk(q, exp);
		// error response only beyond the last mapped word
		chk({31'h0, e}, {31'h0, a > SFC_GAIN1_OFS});
	endtask

	////////////////////////////////////////////////////////////////////////////
	// launch a calibration; with periods given, time rise and run length
	task automatic run_cal(input logic [7:0] word, input logic [6:0] exp_out,
		input int periods);
		int cnt;
		apb_wr(SFC_MODE_OFS, {24'h0, word});
		@(posedge pclk);
		#1;
		chk({31'h0, cal_busy}, 32'h1);
		chk({25'h0, pga_range, chan_sel, exc_ac, chop_active, fs_internal,
			zero_scale_cal}, {25'h0, exp_out});
		if (periods > 0) begin
			cnt = 1;
			// ready_n was low, so it must rise within one modulator cycle
			while (ready_n !== 1'b1 && cnt < 40) begin
				@(posedge pclk);
				#1;
				cnt++;
			end
			chk({31'h0, cnt <= 33}, 32'h1);
			cnt = 0;
			while (ready_n !== 1'b0 && cnt < 3000) begin
				@(posedge pclk);
				#1;
				cnt++;
			end
			chk(32'(cnt), 32'(periods * 32));
		end
	endtask

	// bounded wait for the end of a calibration
	task automatic wait_idle;
		int cnt;
		cnt = 0;
		while (cal_busy !== 1'b0 && cnt < 3000) begin
			@(posedge pclk);
			#1;
			cnt++;
		end
		// a calibration that never ends counts as a mismatch
		if (cnt == 3000)
			fails++;
		chk({31'h0, ready_n}, 32'h0);
	endtask

	////////////////////////////////////////////////////////////////////////////
	// watchdog: whole sequence needs well under 8000 cycles
	initial begin
		repeat (20000) @(posedge pclk);
		fails++;
		results();
	end

	////////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		fails = 0;
		samples_checked = 0;
		presetn = 1'b0;
		{psel, penable, pwrite, conv_req} = 4'h0;
		paddr = 8'h00;
		pwdata = 32'h0;
		fs_lvl = 24'h3a1b2c;
		conv_val = 24'h123456;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		// defaults after reset
		chk({31'h0, ready_n}, 32'h1);
		rd_chk(SFC_MODE_OFS, 32'h0);
		rd_chk(SFC_FILT_OFS, {16'h0, SFC_RDIV_RST, 3'h0, SFC_CHOP_RST});
		rd_chk(SFC_DATA_OFS, {8'h0, SFC_DATA_RST});
		rd_chk(SFC_OFFS0_OFS, {8'h0, SFC_OFFS_RST});
		rd_chk(SFC_OFFS1_OFS, {8'h0, SFC_OFFS_RST});
		rd_chk(SFC_GAIN0_OFS, {8'h0, SFC_GAIN_RST});
		rd_chk(SFC_GAIN1_OFS, {8'h0, SFC_GAIN_RST});
		rd_chk(8'h20, 32'h0);
		// shortest output period: one modulator cycle, chopped
		apb_wr(SFC_FILT_OFS, 32'h11);
		// zero-scale first after power-up, then full-scale
		run_cal(8'h06, 7'b0000101, 0);
		wait_idle();
		rd_chk(SFC_OFFS0_OFS, {8'h0, fs_lvl});
		rd_chk(SFC_GAIN0_OFS, {8'h0, SFC_GAIN_RST});
		// range 2 with ac, then settings rewritten mid-run
		fs_lvl <= 24'h5c6d7e;
		run_cal(8'h37, 7'b1001100, 0);
		apb_wr(SFC_MODE_OFS, 32'h4f);
		@(posedge pclk);
		#1;
		chk({30'h0, pga_range, chan_sel}, 32'h4);
		wait_idle();
		rd_chk(SFC_MODE_OFS, 32'h48);
		rd_chk(SFC_GAIN0_OFS, {8'h0, fs_lvl});
		rd_chk(SFC_GAIN1_OFS, {8'h0, SFC_GAIN_RST});
		rd_chk(SFC_OFFS0_OFS, 32'h3a1b2c);
		rd_chk(SFC_DATA_OFS, {8'h0, SFC_DATA_RST});
		// full-scale alone, chopped: 22 periods
		fs_lvl <= 24'h6e0f01;
		run_cal(8'h07, 7'b0000100, 22);
		rd_chk(SFC_MODE_OFS, 32'h0);
		rd_chk(SFC_GAIN0_OFS, {8'h0, fs_lvl});
		// unchopped, channel 1, range 1: 24 periods
		apb_wr(SFC_FILT_OFS, 32'h10);
		fs_lvl <= 24'h2468ac;
		run_cal(8'h4f, 7'b0110000, 24);
		rd_chk(SFC_GAIN1_OFS, {8'h0, fs_lvl});
		rd_chk(SFC_GAIN0_OFS, 32'h6e0f01);
		// internal full-scale ignores ac: 44 periods chopped
		apb_wr(SFC_FILT_OFS, 32'h11);
		fs_lvl <= 24'h13579b;
		run_cal(8'h25, 7'b0000110, 44);
		rd_chk(SFC_GAIN0_OFS, {8'h0, fs_lvl});
		rd_chk(SFC_MODE_OFS, 32'h20);
		// standby raises ready_n so the conversion must pull it low
		apb_wr(SFC_MODE_OFS, 32'h03);
		@(posedge pclk);
		#1;
		chk({31'h0, ready_n}, 32'h1);
		// single conversion started by the host afterwards
		apb_wr(SFC_MODE_OFS, 32'h02);
		@(posedge pclk);
		conv_req <= 1'b1;
		@(posedge pclk);
		conv_req <= 1'b0;
		repeat (3) @(posedge pclk);
		#1;
		chk({31'h0, ready_n}, 32'h0);
		rd_chk(SFC_DATA_OFS, {8'h0, conv_val});
		rd_chk(SFC_MODE_OFS, 32'h0);
		// continuous mode keeps its code after a result
		apb_wr(SFC_MODE_OFS, 32'h01);
		conv_val <= 24'h654321;
		conv_req <= 1'b1;
		@(posedge pclk);
		conv_req <= 1'b0;
		repeat (3) @(posedge pclk);
		rd_chk(SFC_DATA_OFS, 32'h654321);
		rd_chk(SFC_MODE_OFS, 32'h01);
		results();
	end
endmodule

//--- sfc_front_model.sv
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
// front-end stand-in: full-scale level during calibration, conversion results
module sfc_front_model (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        cal_busy,
	input  wire logic [23:0] fs_level,
	input  wire logic        conv_req,
	input  wire logic [23:0] conv_value,
	output logic      [23:0] cal_meas_word,
	output logic             conv_strobe,
	output logic      [23:0] conv_word
);
	////////////////////////////////////////////////////////////////////////////
	// level held steady while busy, toggling junk otherwise
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cal_meas_word <= 24'h000000;
			conv_strobe   <= 1'b0;
			conv_word     <= 24'h000000;
		end else begin
			// full-scale input kept stable for the whole step
			cal_meas_word <= cal_busy ? fs_level : ~cal_meas_word;
			conv_strobe   <= conv_req;
			// word only meaningful beside the strobe
			conv_word     <= conv_req ? conv_value : ~conv_word;
		end
	end
endmodule

//--- sfc_period_cnt.sv
`timescale 1ns/10ps
module sfc_period_cnt
	import sfc_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	sfc_tim_if.cnt   tim
);
	logic [5:0] per_cnt_reg; // output-rate periods elapsed

	// done on the tick that closes the last period
	assign tim.done = tim.run && tim.rate_tick &&
		(per_cnt_reg == tim.target - 6'h01);

	// counts only while running, idles at zero
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			per_cnt_reg <= 6'h00;
		else if (!tim.run || tim.done)
			per_cnt_reg <= 6'h00;
		else if (tim.rate_tick)
			per_cnt_reg <= per_cnt_reg + 6'h01;
	end
endmodule

//--- sfc_pkg.sv
package sfc_pkg;
	// apb register byte offsets
	localparam logic [7:0] SFC_MODE_OFS   = 8'h00;
	localparam logic [7:0] SFC_FILT_OFS   = 8'h04;
	localparam logic [7:0] SFC_STAT_OFS   = 8'h08;
	localparam logic [7:0] SFC_DATA_OFS   = 8'h0c;
	localparam logic [7:0] SFC_OFFS0_OFS  = 8'h10;
	localparam logic [7:0] SFC_OFFS1_OFS  = 8'h14;
	localparam logic [7:0] SFC_GAIN0_OFS  = 8'h18;
	localparam logic [7:0] SFC_GAIN1_OFS  = 8'h1c;
	// mode register field positions
	localparam int SFC_MD_LSB    = 0;
	localparam int SFC_RANGE_LSB = 3;
	localparam int SFC_AC_BIT    = 5;
	localparam int SFC_CHAN_BIT  = 6;
	// filter register field positions
	localparam int SFC_CHOP_BIT  = 0;
	localparam int SFC_RDIV_LSB  = 4;
	// mode-select codes
	typedef enum logic [2:0] {
		SFC_MD_IDLE   = 3'h0,
		SFC_MD_CONT   = 3'h1,
		SFC_MD_SINGLE = 3'h2,
		SFC_MD_STBY   = 3'h3,
		SFC_MD_IZS    = 3'h4,
		SFC_MD_IFS    = 3'h5,
		SFC_MD_SZS    = 3'h6,
		SFC_MD_SFS    = 3'h7
	} sfc_mode_t;
	// values after reset
	localparam logic [23:0] SFC_OFFS_RST  = 24'h800000;
	localparam logic [23:0] SFC_GAIN_RST  = 24'h400000;
	localparam logic [23:0] SFC_DATA_RST  = 24'h000000;
	localparam logic [11:0] SFC_RDIV_RST  = 12'h050;
	localparam logic        SFC_CHOP_RST  = 1'b1;
	localparam logic        SFC_RDYN_RST  = 1'b1;
	// modulator cycle is pclk/32
	localparam logic [4:0]  SFC_MOD_LAST  = 5'h1f;
	// calibration lengths in output-rate periods
	localparam logic [5:0]  SFC_SYS_CHOP  = 6'h16;
	localparam logic [5:0]  SFC_SYS_NOCH  = 6'h18;
	localparam logic [5:0]  SFC_INT_CHOP  = 6'h2c;
	localparam logic [5:0]  SFC_INT_NOCH  = 6'h30;
endpackage

//--- sfc_tick_gen.sv
`timescale 1ns/10ps
module sfc_tick_gen
	import sfc_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	sfc_tim_if.gen   tim
);
	logic [4:0]  mod_cnt_reg;   // pclk count inside a modulator cycle
	logic [11:0] rate_cnt_reg;  // modulator cycles inside a period

	// terminal counts, a divider of zero acts as one
	wire mod_wrap  = mod_cnt_reg == SFC_MOD_LAST;
	wire rate_last = (rate_cnt_reg + 12'h001) >= tim.rate_div;
	assign tim.mod_tick  = mod_wrap;
	assign tim.rate_tick = mod_wrap && rate_last;

	// free-running dividers, cleared on restart
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mod_cnt_reg  <= 5'h00;
			rate_cnt_reg <= 12'h000;
		end else if (tim.restart) begin
			mod_cnt_reg  <= 5'h00;
			rate_cnt_reg <= 12'h000;
		end else begin
			mod_cnt_reg <= mod_cnt_reg + 5'h01;
			if (mod_wrap)
				rate_cnt_reg <= rate_last ? 12'h000 : rate_cnt_reg + 12'h001;
		end
	end
endmodule

//--- sfc_tim_if.sv
`timescale 1ns/10ps
interface sfc_tim_if;
	logic        mod_tick;  // one pulse per modulator cycle
	logic        rate_tick; // one pulse per output-rate period
	logic        restart;   // realign both dividers
	logic        run;       // period counter enabled
	logic        done;      // last period elapsed
	logic [5:0]  target;    // periods to count
	logic [11:0] rate_div;  // modulator cycles per period
	modport gen (input restart, rate_div, output mod_tick, rate_tick);
	modport cnt (input rate_tick, run, target, output done);
	modport seq (output restart, run, target, rate_div,
		input mod_tick, rate_tick, done);
endinterface
